/* File: copro_model.sv */
// Purpose: coprocessor side model, emulation select and word fetches
// Assumes: shares clock_i with the block, changes signals just after an edge
// Notes:   released fetch addresses show a changed value, never the old one
`timescale 1ns/1ps
`default_nettype none
module copro_model
   import ram_pkg::*;
(
   // clock
   input  wire logic             clock_i,
   // fetch answers
   input  wire logic [1:0][15:0] fetch_data_i,
   // requests towards the block
   output var fetch_req_s [1:0]  fetch_o,
   output var logic      [1:0]   emu_o
);
   // ************************************
   // drivers
   // ************************************
   // idle at time zero
   initial begin
      fetch_o = '0;
      emu_o   = 2'b00;
   end

   // emulation select; caller loads microcode before this
   task automatic set_emu(input logic [1:0] e);
      @(posedge clock_i);
      emu_o <= e;
   endtask : set_emu

   // one fetch on both ports at once, answer taken a cycle later
   task automatic fetch(input logic [11:0] a0, input logic [11:0] a1,
                        output logic [15:0] d0, output logic [15:0] d1);
      @(posedge clock_i);
      fetch_o[0] <= '{req: 1'b1, addr: a0};
      fetch_o[1] <= '{req: 1'b1, addr: a1};
      @(posedge clock_i);
      fetch_o[0] <= '{req: 1'b0, addr: ~a0};
      fetch_o[1] <= '{req: 1'b0, addr: ~a1};
      // answer holds with no request, so take it at the next edge
      @(posedge clock_i);
      d0 = fetch_data_i[0];
      d1 = fetch_data_i[1];
   endtask : fetch

   // back-to-back fetches on both ports, starves the signature engine
   task automatic stream(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock_i);
         fetch_o[0] <= '{req: 1'b1, addr: 12'(i)};
         fetch_o[1] <= '{req: 1'b1, addr: 12'(4095 - i)};
      end
      @(posedge clock_i);
      fetch_o[0] <= '{req: 1'b0, addr: 12'h5a5};
      fetch_o[1] <= '{req: 1'b0, addr: 12'ha5a};
   endtask : stream
endmodule : copro_model
`default_nettype wire

/* File: dual_port_microcode_ram_modes_tb.sv */
// Purpose: self-checking bench for RAM modes, host access and signature
// Assumes: avalon slave raises waitrequest low once per request
// Notes:   whole array is filled so the signature is known in advance
`timescale 1ns/1ps
`default_nettype none
module dual_port_microcode_ram_modes_tb
   import ram_pkg::*;
();
   // ************************************
   // signals and constants
   // ************************************
   localparam logic [23:0] A_CFG  = {REG_BLOCK, OFF_CFG};
   localparam logic [23:0] A_BASE = {REG_BLOCK, OFF_BASE};
   localparam logic [23:0] A_SIGH = {REG_BLOCK, OFF_SIGH};
   localparam logic [23:0] A_SIGL = {REG_BLOCK, OFF_SIGL};
   localparam logic [23:0] A_CNT  = {REG_BLOCK, OFF_CNT};
   localparam logic [23:0] A_HOLE = {REG_BLOCK, 5'h1c};
   localparam logic [23:0] ARR    = 24'h002000;
   localparam int          CEIL   = 60000;   // whole run needs about 13000

   logic                   clock_i;
   logic                   rst_i;
   logic [23:0]            address_i;
   logic                   read_i;
   logic                   write_i;
   logic [31:0]            writedata_i;
   logic [3:0]             byteenable_i;
   logic [31:0]            readdata_o;
   logic                   waitrequest_o;
   logic                   freeze_i;
   logic [1:0]             emu_i;
   fetch_req_s [1:0]       fetch_i;
   logic [1:0][15:0]       fetch_data_o;
   int                     err_count = 0;
   int                     total_checks = 0;
   int                     cycles = 0;

   microcode_ram_top DUT (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .byteenable_i(byteenable_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .freeze_i(freeze_i), .emu_i(emu_i),
      .fetch_i(fetch_i), .fetch_data_o(fetch_data_o));

   copro_model u_copro (.clock_i(clock_i), .fetch_data_i(fetch_data_o),
      .fetch_o(fetch_i), .emu_o(emu_i));

   // ************************************
   // helpers
   // ************************************
   // free-running clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   function automatic logic [31:0] pat(input int i);
      return {16'(i) ^ 16'h3c00, 16'(i * 7) ^ 16'ha5a5};
   endfunction : pat

   function automatic logic [23:0] aw(input int i);
      return ARR + 24'(i * 4);
   endfunction : aw

   // top word is read first, word 0 last
   function automatic logic [31:0] sig_exp();
      logic [31:0] s;
      s = 32'h0;
      for (int i = ARR_WORDS - 1; i >= 0; i--)
         s = (s << 1) ^ (s[MISR_FB] ? MISR_TAPS : 32'h0) ^ pat(i);
      return s;
   endfunction : sig_exp

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // request held until waitrequest is sampled low; only the timeout ends it
   task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] d);
      @(posedge clock_i);
      address_i    <= a;
      writedata_i  <= wd;
      byteenable_i <= be;
      read_i       <= ~wr;
      write_i      <= wr;
      do @(posedge clock_i); while (waitrequest_o !== 1'b0);
      d = readdata_o;
      read_i  <= 1'b0;
      write_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [23:0] a, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] x;
      bus(1'b1, a, wd, be, x);
   endtask : wr

   task automatic rchk(input logic [23:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, 4'hf, x);
      check(x, e);
   endtask : rchk

   // poll done with a bound, then read both halves
   task automatic sig_ok(input logic [31:0] e);
      logic [31:0] x;
      int          k;
      k = 0;
      do begin
         bus(1'b0, A_CFG, 32'h0, 4'hf, x);
         k++;
      end while (x[CFG_DONE] !== 1'b1 && k < 2000);
      check(x & 32'h4, 32'h4);
      rchk(A_SIGH, {16'h0, e[31:16]});
      rchk(A_SIGL, {16'h0, e[15:0]});
   endtask : sig_ok

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // hang guard
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == CEIL) begin
         err_count++;
         summarize();
      end
   end

   // ************************************
   // sequence
   // ************************************
   initial begin
      logic [31:0] x, y, p5, p9, sig;
      logic [15:0] h0, h1;
      rst_i = 1'b1;
      address_i = 24'h0;
      read_i = 1'b0;
      write_i = 1'b0;
      writedata_i = 32'h0;
      byteenable_i = 4'hf;
      freeze_i = 1'b0;
      p5 = pat(5);
      p9 = pat(9);
      sig = sig_exp();
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      rchk(A_CFG, 32'h0);
      rchk(A_BASE, 32'h1);
      rchk(ARR, 32'h0);
      rchk(A_HOLE, 32'h0);
      wr(A_BASE, 32'h20, 4'hf);
      rchk(A_BASE, 32'h20);
      wr(ARR, 32'h11223344, 4'hf);
      wr(ARR, 32'h000000aa, 4'h1);
      wr(ARR, 32'hbbbb0000, 4'hc);
      rchk(ARR, 32'hbbbb33aa);
      for (int i = 0; i < ARR_WORDS; i++)
         wr(aw(i), pat(i), 4'hf);
      @(posedge clock_i);
      freeze_i <= 1'b1;                   // held high from here on
      rchk(aw(5), p5);
      wr(A_CFG, 32'h1, 4'hf);
      rchk(A_CFG, 32'h1);
      wr(aw(5), 32'h0, 4'hf);
      rchk(aw(5), 32'h0);
      wr(A_CFG, 32'h0, 4'hf);
      rchk(aw(5), p5);
      u_copro.fetch(12'h00a, 12'h013, h0, h1);
      check({h0, h1}, 32'h0);
      wr(A_CFG, 32'h2, 4'hf);
      repeat (2100) @(posedge clock_i);
      rchk(A_CFG, 32'h2);
      u_copro.set_emu(2'b01);
      rchk(aw(5), 32'h0);
      wr(aw(5), 32'h0, 4'hf);
      u_copro.fetch({11'd5, 1'b0}, {11'd9, 1'b1}, h0, h1);
      check({h0, h1}, {p5[31:16], p9[15:0]});
      fork
         u_copro.stream(30);
         begin
            repeat (2) @(posedge clock_i);
            bus(1'b0, A_CNT, 32'h0, 4'hf, x);
            bus(1'b0, A_CNT, 32'h0, 4'hf, y);
         end
      join
      check(y, x);
      sig_ok(sig);
      wr(A_CFG, 32'h6, 4'hf);             // done cleared, enable kept
      rchk(A_CFG, 32'h2);
      repeat (500) @(posedge clock_i);
      wr(A_CFG, 32'h0, 4'hf);
      wr(A_CFG, 32'h2, 4'hf);
      sig_ok(sig);
      u_copro.set_emu(2'b00);
      rchk(A_SIGH, 32'h0);
      rchk(A_SIGL, 32'h0);
      rchk(aw(5), p5);
      summarize();
   end
endmodule : dual_port_microcode_ram_modes_tb
`default_nettype wire

/* File: microcode_ram_top.sv */
// Purpose: mode control, host access and signature engine for the RAM
// Assumes: bus master, emulation selects and fetches share clock_i
// Notes:   answers every request one cycle after it is seen
`timescale 1ns/1ps
`default_nettype none
module microcode_ram_top
   import ram_pkg::*;
(
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // avalon-mm slave
   input  wire logic [23:0]      address_i,
   input  wire logic             read_i,
   input  wire logic             write_i,
   input  wire logic [31:0]      writedata_i,
   input  wire logic [3:0]       byteenable_i,
   output logic      [31:0]      readdata_o,
   output logic                  waitrequest_o,
   // host bus freeze line
   input  wire logic             freeze_i,
   // coprocessor side
   input  wire logic [1:0]       emu_i,
   input  wire fetch_req_s [1:0] fetch_i,
   output logic [1:0][15:0]      fetch_data_o
);

   // ******************************
   // state
   // ******************************
   logic              stop_reg;
   logic              sig_en_reg;
   logic              done_reg;
   logic              dis_reg;
   logic [10:0]       base_reg;
   logic [31:0]       sig_out_reg;
   logic [31:0]       acc_reg;
   logic [ARR_AW-1:0] cnt_reg;
   logic [ARR_AW-1:0] last_reg;
   logic              wait_reg;
   logic [31:0]       rd_reg;
   logic [1:0][15:0]  fd_reg;

   // ******************************
   // decode
   // ******************************
   logic              req;
   logic              take;
   logic              emulation_select_bit;
   logic              in_regs;
   logic              arr_ok;
   logic [4:0]        off;
   logic              wr_cfg;
   logic              wr_base;
   logic              arr_we;
   logic              sig_run;
   logic              sig_rd;
   logic              pass_end;
   logic [31:0]       acc_next;
   logic [31:0]       arr_rdata;
   logic [31:0]       fdata [2];
   logic [31:0]       rd_mux;

   // freeze_i is left unread on purpose: the block keeps its mode
   assign emulation_select_bit     = |emu_i;
   assign req     = read_i | write_i;
   assign take    = req && !wait_reg;
   assign off     = address_i[4:0];
   assign in_regs = address_i[23:5] == REG_BLOCK;

   // array answers only when enabled, awake and not handed over
   assign arr_ok  = !dis_reg && !stop_reg && !emulation_select_bit
                 && address_i[23:13] == base_reg;

   assign wr_cfg  = take && write_i && in_regs && off == OFF_CFG;
   assign wr_base = take && write_i && in_regs && off == OFF_BASE;
   assign arr_we  = take && write_i && !in_regs && arr_ok;

   // ******************************
   // storage
   // ******************************
   ram_array u_array (
      .clock_i  (clock_i),
      .we_i     (arr_we),
      .waddr_i  (address_i[12:2]),
      .wdata_i  (writedata_i),
      .be_i     (byteenable_i),
      .raddr_i  (sig_rd ? cnt_reg : address_i[12:2]),
      .rdata_o  (arr_rdata),
      .faddr0_i (fetch_i[0].addr[11:1]),
      .faddr1_i (fetch_i[1].addr[11:1]),
      .fdata0_o (fdata[0]),
      .fdata1_o (fdata[1])
   );

   // ******************************
   // bus handshake
   // ******************************
   // wait drops one cycle after a request, commit happens on the low edge
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wait_reg <= 1'b1;
      end else if (req && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   // read mux; unmapped or refused addresses read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (in_regs) begin
         case (off)
            OFF_CFG: begin
               rd_mux[CFG_STOP]  = stop_reg;
               rd_mux[CFG_SIGEN] = sig_en_reg;
               rd_mux[CFG_DONE]  = done_reg;
            end
            OFF_BASE: begin
               rd_mux[BASE_MSB:BASE_LSB] = base_reg;
               rd_mux[BASE_DIS]          = dis_reg;
            end
            OFF_SIGH: rd_mux[15:0] = sig_out_reg[31:16];
            OFF_SIGL: rd_mux[15:0] = sig_out_reg[15:0];
            OFF_CNT:  rd_mux[15:0] = {last_reg, 2'b00, 3'b000};
            default:  rd_mux = 32'h0000_0000;
         endcase
      end else if (arr_ok) begin
         rd_mux = arr_rdata;
      end
   end

   // read data captured as wait drops, held through the commit cycle
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_reg <= 32'h0000_0000;
      end else if (req && wait_reg) begin
         rd_reg <= read_i ? rd_mux : 32'h0000_0000;
      end
   end

   assign readdata_o    = rd_reg;
   assign waitrequest_o = wait_reg;

   // ******************************
   // configuration
   // ******************************
   // stop stays writable even while set so software can wake the block
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stop_reg   <= 1'b0;
         sig_en_reg <= 1'b0;
      end else if (wr_cfg) begin
         stop_reg   <= writedata_i[CFG_STOP];
         sig_en_reg <= writedata_i[CFG_SIGEN];
      end
   end

   // base write enables the array; disabled after reset
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         base_reg <= BASE_RST;
         dis_reg  <= DIS_RST;
      end else if (wr_base) begin
         base_reg <= writedata_i[BASE_MSB:BASE_LSB];
         dis_reg  <= 1'b0;
      end
   end

   // ******************************
   // signature engine
   // ******************************
   // the gated module clock is modelled by freezing the engine in stop
   assign sig_run  = emulation_select_bit && sig_en_reg && !stop_reg;
   assign sig_rd   = sig_run && !fetch_i[0].req && !fetch_i[1].req;
   assign pass_end = sig_rd && cnt_reg == '0;

   misr_step #(.W(32)) u_step (
      .state_i (acc_reg),
      .data_i  (arr_rdata),
      .next_o  (acc_next)
   );

   // descending walk; restart fresh at the top after address zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg  <= ARR_TOP;
         acc_reg  <= 32'h0000_0000;
         last_reg <= '0;
      end else if (!emulation_select_bit || !sig_en_reg) begin
         cnt_reg  <= ARR_TOP;
         acc_reg  <= 32'h0000_0000;
         last_reg <= '0;
      end else if (sig_rd) begin
         last_reg <= cnt_reg;
         if (pass_end) begin
            cnt_reg <= ARR_TOP;
            acc_reg <= 32'h0000_0000;
         end else begin
            cnt_reg <= cnt_reg - 1'b1;
            acc_reg <= acc_next;
         end
      end
   end

   // result loads every pass; cleared when emulation ends
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sig_out_reg <= 32'h0000_0000;
      end else if (!emulation_select_bit) begin
         sig_out_reg <= 32'h0000_0000;
      end else if (pass_end) begin
         sig_out_reg <= acc_next;
      end
   end

   // done flag: write one to clear, a new pass end wins over the clear
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         done_reg <= 1'b0;
      end else if (pass_end) begin
         done_reg <= 1'b1;
      end else if (wr_cfg && writedata_i[CFG_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   // ******************************
   // coprocessor fetch
   // ******************************
   // registered fetch data; updates only in emulation and holds its last value outside it, so normal mode is untouched
   for (genvar k = 0; k < 2; k++) begin : g_fetch
      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            fd_reg[k] <= 16'h0000;
         end else if (emulation_select_bit && fetch_i[k].req) begin
            fd_reg[k] <= fetch_i[k].addr[0] ? fdata[k][15:0]
                                            : fdata[k][31:16];
         end
      end
   end

   assign fetch_data_o = fd_reg;

   // ******************************
   // checks
   // ******************************
   a_stop_no_write: assert property (@(posedge clock_i) disable iff (rst_i)
      stop_reg |-> !arr_we) else $error("array written in stop");

   a_emu_no_host: assert property (@(posedge clock_i) disable iff (rst_i)
      emulation_select_bit |-> !arr_we && !arr_ok && (in_regs || rd_mux == 32'h0000_0000))
      else $error("host reached array in emulation");

   a_sig_gate: assert property (@(posedge clock_i) disable iff (rst_i)
      sig_rd |-> emulation_select_bit && sig_en_reg && !stop_reg)
      else $error("signature read outside emulation");

   a_sig_yield: assert property (@(posedge clock_i) disable iff (rst_i)
      sig_rd |-> !fetch_i[0].req && !fetch_i[1].req)
      else $error("signature read beat a fetch");

   a_pass_load: assert property (@(posedge clock_i) disable iff (rst_i)
      pass_end |=> done_reg && sig_out_reg == $past(acc_next)
                   && cnt_reg == ARR_TOP && acc_reg == 32'h0000_0000)
      else $error("pass end not recorded");

   a_leave_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(emulation_select_bit) |=> sig_out_reg == 32'h0000_0000 && last_reg == '0)
      else $error("leaving emulation kept signature");

   a_en_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(sig_en_reg) |=> last_reg == '0 && cnt_reg == ARR_TOP)
      else $error("counter kept after disable");

   a_base_enable: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_base |=> !dis_reg) else $error("base write left array disabled");

   a_wait_one: assert property (@(posedge clock_i) disable iff (rst_i)
      req && wait_reg |=> !waitrequest_o ##1 waitrequest_o)
      else $error("answer not one cycle after request");

   a_walk_down: assert property (@(posedge clock_i) disable iff (rst_i)
      sig_rd && !pass_end && emulation_select_bit && sig_en_reg
      |=> (!emulation_select_bit || !sig_en_reg || cnt_reg == $past(cnt_reg) - 11'h001))
      else $error("signature address not descending");

endmodule : microcode_ram_top
`default_nettype wire

/* File: misr_step.sv */
// Purpose: one step of the multiple-input signature register
// Assumes: feedback taken from the degree-31 term
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module misr_step
   import ram_pkg::*;
#(
   parameter int W = 32
) (
   // state and input word
   input  wire logic [W-1:0] state_i,
   input  wire logic [W-1:0] data_i,
   // next state
   output logic      [W-1:0] next_o
);

   // shift, fold feedback into the tap positions, then mix in data
   assign next_o = {state_i[W-2:0], 1'b0}
                 ^ ({W{state_i[MISR_FB]}} & MISR_TAPS[W-1:0])
                 ^ data_i;

endmodule : misr_step
`default_nettype wire

/* File: ram_array.sv */
// Purpose: flip-flop storage for the microcode array
// Assumes: one byte-lane write port, one host/signature read, two fetch reads
// Notes:   no reset on storage so contents survive stop and mode changes
`timescale 1ns/1ps
`default_nettype none
module ram_array
   import ram_pkg::*;
(
   // clock
   input  wire logic              clock_i,
   // write port
   input  wire logic              we_i,
   input  wire logic [ARR_AW-1:0] waddr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        be_i,
   // shared read port
   input  wire logic [ARR_AW-1:0] raddr_i,
   output logic      [31:0]       rdata_o,
   // fetch read ports
   input  wire logic [ARR_AW-1:0] faddr0_i,
   input  wire logic [ARR_AW-1:0] faddr1_i,
   output logic      [31:0]       fdata0_o,
   output logic      [31:0]       fdata1_o
);

   logic [31:0] mem [ARR_WORDS];

   // byte lanes let the host write 8, 16 or 32 bits
   for (genvar b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge clock_i) begin
         if (we_i && be_i[b]) begin
            mem[waddr_i][8*b +: 8] <= wdata_i[8*b +: 8];
         end
      end
   end

   // independent reads so both fetches run in the same cycle
   assign rdata_o  = mem[raddr_i];
   assign fdata0_o = mem[faddr0_i];
   assign fdata1_o = mem[faddr1_i];

endmodule : ram_array
`default_nettype wire

/* File: ram_pkg.sv */
// Purpose: shared constants and carriers for the microcode RAM block
// Assumes: 100 MHz clock_i, Avalon-MM register bus, 24-bit byte addresses
// Notes:   array is 8 KB held as 2048 words of 32 bits
//
// Contract
// - stop bit puts module in lowest power; config register stays writable.
// - in stop mode array reads and writes are refused, contents kept.
// - bus interface stays alive in stop; module clock stays off until cleared.
// - reset clears the stop bit so module starts active.
// - freeze line has no effect; current mode continues.
// - under freeze array stays host-reachable if enabled; fetches continue.
// - emulation select hands the array to coprocessors, off the host bus.
// - both coprocessors fetch words at once, up to 40 MHz.
// - in emulation host array accesses are ignored; control has no effect. Code still applies config and base writes in emulation.
// - signature reads only in emulation with signature enable set.
// - signature reads descend through addresses into one 32-bit value.
// - signature reads only in cycles without coprocessor fetch requests.
// - signature uses shift register with polynomial 1+x+x^2+x^22+x^31.
// - after a full pass the signature done flag is set.
// - signature registers load at end of every pass, read or not.
// - clearing enable stops signature; enable resets to disabled.
// - leaving emulation clears both signature registers.
// - leaving emulation or clearing enable resets the address counter.
// - disabled flag set by reset, cleared by base write; gates host addresses.
// - normal mode accepts 8, 16, 32-bit accesses; coprocessors have no effect.
package ram_pkg;

   // ******************************
   // array geometry
   // ******************************
   localparam int          ARR_AW    = 11;
   localparam int          ARR_WORDS = 2048;
   localparam logic [10:0] ARR_TOP   = 11'h7ff;

   // ******************************
   // register map (byte offsets in a 32-byte block)
   // ******************************
   localparam logic [18:0] REG_BLOCK = 19'h7ffc4;   // block at 0xfff880
   localparam logic [4:0]  OFF_CFG   = 5'h00;
   localparam logic [4:0]  OFF_BASE  = 5'h04;
   localparam logic [4:0]  OFF_SIGH  = 5'h08;
   localparam logic [4:0]  OFF_SIGL  = 5'h0c;
   localparam logic [4:0]  OFF_CNT   = 5'h10;

   // ******************************
   // field positions and reset values
   // ******************************
   localparam int          CFG_STOP  = 0;
   localparam int          CFG_SIGEN = 1;
   localparam int          CFG_DONE  = 2;
   localparam int          BASE_LSB  = 5;
   localparam int          BASE_MSB  = 15;
   localparam int          BASE_DIS  = 0;
   localparam logic [10:0] BASE_RST  = 11'h000;
   localparam logic        DIS_RST   = 1'b1;

   // ******************************
   // signature feedback taps for x^0, x^1, x^2, x^22 (x^31 is the top)
   // ******************************
   localparam logic [31:0] MISR_TAPS = 32'h0040_0007;
   localparam int          MISR_FB   = 30;

   // ******************************
   // coprocessor fetch carrier
   // ******************************
   typedef struct packed {
      logic        req;
      logic [11:0] addr;   // 16-bit word address
   } fetch_req_s;

endpackage : ram_pkg
